// ---- rtl/mss_pkg.sv ----
// package for the memory set and skip execution block
// assumes a core that issues one decoded instruction per cycle
package mss_pkg;
    localparam int MSS_DATA_W = 8;               // data memory word width
    localparam int MSS_ADDR_W = 6;               // data memory address width
    localparam int MSS_BIT_W = 3;                // bit select width
    localparam logic [7:0] MSS_ALL_ONES = 8'hFF; // fill pattern
    localparam logic [7:0] MSS_ONE = 8'h01;      // increment step
    localparam logic [7:0] MSS_ZERO = 8'h00;     // wrap value
    localparam logic [7:0] MSS_WORK_RST = 8'h00; // working register reset value
    localparam int MSS_SKIP_CYCLES = 2;          // taken skip length
    localparam int MSS_PLAIN_CYCLES = 1;         // normal length

    // operation selector
    typedef enum logic [2:0] {
        MSS_OP_NONE,
        MSS_OP_FILL,
        MSS_OP_BIT_SET,
        MSS_OP_INCR_SKIP,
        MSS_OP_INCR_WORK,
        MSS_OP_BIT_TEST
    } mss_op_t;

    // one issued instruction
    typedef struct packed {
        mss_op_t op;
        logic [5:0] addr;
        logic [2:0] bit_sel;
    } mss_instr_t;

    // flag group held by the core
    typedef struct packed {
        logic timeout;
        logic power_down;
        logic overflow;
        logic zero;
        logic aux_carry;
        logic carry;
    } mss_flags_t;
endpackage

// ---- rtl/mss_alu.sv ----
// combinational result unit for the set and skip group
// assumes the memory byte is read in the same cycle as the instruction
`timescale 1ns/1ns
`default_nettype none
module mss_alu
    import mss_pkg::*;
(
    input wire mss_op_t op,
    input wire logic [7:0] mem_rd,
    input wire logic [2:0] bit_sel,
    output logic [7:0] result,
    output logic skip_cond,
    output logic mem_we,
    output logic work_we
);
    wire [7:0] bit_mask = MSS_ONE << bit_sel; // one hot select
    wire [7:0] incr = mem_rd + MSS_ONE;       // wraps naturally at 8 bits
    wire incr_zero = (incr == MSS_ZERO);
    wire bit_hit = (mem_rd & bit_mask) != MSS_ZERO;

    // result and strobe selection
    always_comb begin
        result = mem_rd;
        skip_cond = 1'b0;
        mem_we = 1'b0;
        work_we = 1'b0;
        case (op)
            MSS_OP_FILL: begin
                result = MSS_ALL_ONES;
                mem_we = 1'b1;
            end
            MSS_OP_BIT_SET: begin
                result = mem_rd | bit_mask;
                mem_we = 1'b1;
            end
            MSS_OP_INCR_SKIP: begin
                result = incr;
                mem_we = 1'b1;
                skip_cond = incr_zero;
            end
            MSS_OP_INCR_WORK: begin
                result = incr;
                work_we = 1'b1;
                skip_cond = incr_zero;
            end
            MSS_OP_BIT_TEST: begin
                skip_cond = bit_hit;
            end
            default: begin
                result = mem_rd;
            end
        endcase
    end
endmodule // mss_alu
`default_nettype wire

// ---- rtl/mss_exec.sv ----
// execution stage for fill, bit set, increment skip and bit test
// assumes a single port data memory with same cycle combinational read
// and a fetch unit that honours flush and stall
`timescale 1ns/1ns
`default_nettype none
// How it works
// - fill writes all ones into byte
// - bit set forces only chosen bit
// - increment writes back, skips on wrap
// - taken skip flushes prefetch, adds dummy
// - untaken skip finishes in one cycle
// - working variant writes register, memory untouched
// - working variant skips when sum zero
// - bit test skips when bit set
module mss_exec
    import mss_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire mss_instr_t instr,     // decoded instruction, same clock
    input wire logic instr_valid,     // instruction issued this cycle
    input wire logic [7:0] mem_rd_data,
    input wire mss_flags_t flags_in,  // current status flags
    output logic [5:0] mem_addr,
    output logic [7:0] mem_wr_data,
    output logic mem_wr_en,
    output logic [7:0] working_register,
    output mss_flags_t flags_out,
    output logic flush,               // discard prefetched instruction
    output logic busy                 // dummy cycle in progress
);
    // two states: normal execute, or the dummy cycle after a taken skip
    typedef enum logic {MSS_EXEC, MSS_DUMMY} mss_state_t;

    mss_state_t state_r, state_nxt;
    logic [7:0] work_r, work_nxt;      // working register
    logic [7:0] wdata_r;               // registered memory write data
    logic [5:0] waddr_r;               // registered memory address
    logic wen_r;                       // registered write strobe
    mss_flags_t flags_r;               // flag copy, never altered here

    logic [7:0] result;
    logic skip_cond, alu_mem_we, alu_work_we;

    // an instruction only acts outside the dummy cycle
    wire issue = instr_valid && (state_r == MSS_EXEC);
    wire mss_op_t op_eff = issue ? instr.op : MSS_OP_NONE;
    wire skip_taken = issue && skip_cond;

    mss_alu u_alu (
        .op(op_eff),
        .mem_rd(mem_rd_data),
        .bit_sel(instr.bit_sel),
        .result(result),
        .skip_cond(skip_cond),
        .mem_we(alu_mem_we),
        .work_we(alu_work_we)
    );

    // next state: a taken skip costs exactly one extra cycle
    always_comb begin
        state_nxt = MSS_EXEC;
        case (state_r)
            MSS_EXEC: state_nxt = skip_taken ? MSS_DUMMY : MSS_EXEC;
            MSS_DUMMY: state_nxt = MSS_EXEC;
            default: state_nxt = MSS_EXEC;
        endcase
    end

    // working register only moves for the working variant
    assign work_nxt = alu_work_we ? result : work_r;

    // state and datapath registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= MSS_EXEC;
            work_r <= MSS_WORK_RST;
            wdata_r <= MSS_ZERO;
            waddr_r <= '0;
            wen_r <= 1'b0;
            flags_r <= '0;
        end else begin
            state_r <= state_nxt;
            work_r <= work_nxt;
            wdata_r <= result;
            waddr_r <= instr.addr;
            wen_r <= alu_mem_we;
            flags_r <= flags_in;
        end
    end

    // read address is live so the memory byte arrives in the issue cycle;
    // the write lands one edge later, which keeps the read path clean
    assign mem_addr = wen_r ? waddr_r : instr.addr;
    assign mem_wr_data = wdata_r;
    assign mem_wr_en = wen_r;
    assign working_register = work_r;
    assign flags_out = flags_r;
    assign flush = skip_taken;
    assign busy = (state_r == MSS_DUMMY);

    // limitation: back to back issue into a pending write address is
    // the fetch unit's concern; the write port has priority

    skip_dummy_a: assert property (@(posedge clk) disable iff (!rst_n)
        skip_taken |=> busy ##1 !busy)
        else $error("taken skip did not add exactly one dummy cycle");
    no_skip_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && !skip_cond) |=> !busy)
        else $error("untaken skip stalled");
    fill_ones_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op == MSS_OP_FILL) |=> mem_wr_en && mem_wr_data == 8'hFF)
        else $error("fill did not write all ones");
    bit_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op == MSS_OP_BIT_SET) |=> mem_wr_en &&
        mem_wr_data == ($past(mem_rd_data) | (8'h01 << $past(instr.bit_sel))))
        else $error("bit set wrote wrong value");
    incr_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op == MSS_OP_INCR_SKIP) |=> mem_wr_en &&
        mem_wr_data == 8'($past(mem_rd_data) + 8'h01))
        else $error("increment write back wrong");
    incr_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op inside {MSS_OP_INCR_SKIP, MSS_OP_INCR_WORK})
        |-> flush == (mem_rd_data == 8'hFF))
        else $error("increment skip decision wrong");
    work_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op == MSS_OP_INCR_WORK) |=> !mem_wr_en &&
        working_register == 8'($past(mem_rd_data) + 8'h01))
        else $error("working variant touched memory or missed register");
    work_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op == MSS_OP_INCR_WORK && mem_rd_data != 8'hFF) |-> !flush)
        else $error("working variant skipped on nonzero");
    bit_test_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op == MSS_OP_BIT_TEST) |-> flush == mem_rd_data[instr.bit_sel])
        else $error("bit test skip decision wrong");
    flags_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> flags_out == $past(flags_in))
        else $error("flags altered");

    skip_taken_c: cover property (@(posedge clk) disable iff (!rst_n) skip_taken ##1 busy);
    wrap_c: cover property (@(posedge clk) disable iff (!rst_n)
        issue && instr.op == MSS_OP_INCR_SKIP && mem_rd_data == 8'hFF);
    bit_test_c: cover property (@(posedge clk) disable iff (!rst_n)
        issue && instr.op == MSS_OP_BIT_TEST && !skip_cond);
    work_c: cover property (@(posedge clk) disable iff (!rst_n)
        issue && instr.op == MSS_OP_INCR_WORK);
    bit_set_c: cover property (@(posedge clk) disable iff (!rst_n)
        issue && instr.op == MSS_OP_BIT_SET && instr.bit_sel == 3'h7);

    // the write must land on the byte that was read in the issue cycle;
    // the address is held in waddr_r, so a slip here would corrupt a
    // neighbouring byte without any visible error on the data path
    write_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && alu_mem_we) |=>
        mem_wr_en && mem_addr == $past(instr.addr))
        else $error("write went to the wrong address");

    // the dummy cycle never starts a write of its own; only the write
    // of the skipping instruction itself may still be landing there
    dummy_no_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        busy |=> !mem_wr_en)
        else $error("dummy cycle produced a write");

    // a flush must only come from an instruction that was really taken;
    // an offered instruction inside the dummy cycle is refused entirely
    flush_issue_a: assert property (@(posedge clk) disable iff (!rst_n)
        flush |-> (issue && !busy))
        else $error("flush without an accepted instruction");

    // the bit test only reads: neither the byte nor the working
    // register may move because of it
    test_read_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op == MSS_OP_BIT_TEST) |=>
        !mem_wr_en && $stable(working_register))
        else $error("bit test changed state");

    // memory variants must leave the working register alone; only the
    // working variant is allowed to load it
    mem_ops_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op inside {MSS_OP_FILL, MSS_OP_BIT_SET, MSS_OP_INCR_SKIP}) |=>
        $stable(working_register))
        else $error("memory variant changed the working register");

    // the working variant must skip when the byte wraps; the partner
    // assertion above only covers the nonzero side of the decision
    work_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op == MSS_OP_INCR_WORK && mem_rd_data == 8'hFF) |-> flush)
        else $error("working variant missed the skip on wrap");

    // a taken skip on the working variant still loads the register
    work_wrap_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        (issue && instr.op == MSS_OP_INCR_WORK && mem_rd_data == 8'hFF) |=>
        working_register == MSS_ZERO)
        else $error("working variant lost the wrapped value");
endmodule // mss_exec
`default_nettype wire

// ---- tb/test_memory_set_and_skip_exec.sv ----
// testbench for the set and skip execution stage
// assumes the stage and its package compile first; memory is modelled here
`timescale 1ns/1ns
`default_nettype none
module test_memory_set_and_skip_exec;
    import mss_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    mss_instr_t instr = '0;
    logic instr_valid = 1'b0;
    logic [7:0] mem_rd_data; // combinational read of the model
    mss_flags_t flags_in = '0;
    logic [5:0] mem_addr;
    logic [7:0] mem_wr_data;
    logic mem_wr_en;
    logic [7:0] working_register;
    mss_flags_t flags_out;
    logic flush;
    logic busy;
    logic [7:0] mem [0:63]; // data memory model, 64 bytes
    int n_fail = 0;
    int checks_done = 0;

    mss_exec dut (.clk(clk), .rst_n(rst_n), .instr(instr), .instr_valid(instr_valid),
        .mem_rd_data(mem_rd_data), .flags_in(flags_in), .mem_addr(mem_addr),
        .mem_wr_data(mem_wr_data), .mem_wr_en(mem_wr_en),
        .working_register(working_register), .flags_out(flags_out),
        .flush(flush), .busy(busy));

    // single port memory: same cycle read, write on the edge
    assign mem_rd_data = mem[mem_addr];
    always @(posedge clk) begin
        if (mem_wr_en === 1'b1) begin
            mem[mem_addr] <= mem_wr_data;
        end
    end

    // free running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // issue one op; during a dummy cycle a fill to 3F is offered and must be ignored
    task automatic run(input mss_op_t op, input logic [5:0] a, input logic [2:0] b,
        input logic sk, input logic we);
        @(negedge clk);
        instr = '{op: op, addr: a, bit_sel: b};
        instr_valid = 1'b1;
        #4;
        chk("flush", {7'h00, sk}, {7'h00, flush});
        @(negedge clk);
        instr = '{op: MSS_OP_FILL, addr: 6'h3F, bit_sel: 3'h0};
        instr_valid = sk;
        chk("busy", {7'h00, sk}, {7'h00, busy});
        chk("write strobe", {7'h00, we}, {7'h00, mem_wr_en});
        if (we) begin
            chk("write address", {2'h0, a}, {2'h0, mem_addr});
        end
        @(negedge clk);
        instr_valid = 1'b0;
        chk("byte 3F", 8'h12, mem[63]);
        chk("flags out", {2'h0, flags_in}, {2'h0, flags_out});
    endtask

    task automatic fill_case;
        run(MSS_OP_FILL, 6'h01, 3'h0, 1'b0, 1'b1);
        chk("fill byte", 8'hFF, mem[1]);
    endtask

    task automatic bit_set_case;
        run(MSS_OP_BIT_SET, 6'h03, 3'h1, 1'b0, 1'b1);
        chk("bit set low", 8'h42, mem[3]);
        run(MSS_OP_BIT_SET, 6'h06, 3'h7, 1'b0, 1'b1);
        chk("bit set high", 8'h84, mem[6]);
    endtask

    // wrap case is followed by a plain one: lost dummy cycle and one idle cycle, then accept
    task automatic incr_case;
        run(MSS_OP_INCR_SKIP, 6'h02, 3'h0, 1'b1, 1'b1);
        chk("wrap byte", 8'h00, mem[2]);
        run(MSS_OP_INCR_SKIP, 6'h05, 3'h0, 1'b0, 1'b1);
        chk("incr byte", 8'h80, mem[5]);
    endtask

    // plain value first so the wrap result differs from the value held before it
    task automatic work_case;
        run(MSS_OP_INCR_WORK, 6'h03, 3'h0, 1'b0, 1'b0);
        chk("working plain", 8'h43, working_register);
        chk("source kept", 8'h42, mem[3]);
        run(MSS_OP_INCR_WORK, 6'h04, 3'h0, 1'b1, 1'b0);
        chk("working wrap", 8'h00, working_register);
        chk("wrap source kept", 8'hFF, mem[4]);
    endtask

    task automatic bit_test_case;
        run(MSS_OP_BIT_TEST, 6'h06, 3'h7, 1'b1, 1'b0);
        run(MSS_OP_BIT_TEST, 6'h06, 3'h0, 1'b0, 1'b0);
        chk("tested byte", 8'h84, mem[6]);
    endtask

    // prints the verdict and stops the run
    task automatic end_of_test;
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end

    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 8'h12;
        end
        mem[2] = 8'hFF;
        mem[3] = 8'h40;
        mem[4] = 8'hFF;
        mem[5] = 8'h7F;
        mem[6] = 8'h04;
        repeat (2) @(negedge clk);
        chk("reset working", MSS_WORK_RST, working_register);
        rst_n = 1'b1;
        flags_in = 6'h2A;
        fill_case();
        bit_set_case();
        flags_in = 6'h15;
        incr_case();
        work_case();
        bit_test_case();
        end_of_test();
    end
endmodule // test_memory_set_and_skip_exec
`default_nettype wire
